//--- ssp_pkg.sv
// package: shared types and constants of the serial port controller
package ssp_pkg;

   // -----------------------------------------------------------------
   // reset values and fixed codes
   // -----------------------------------------------------------------
   localparam logic [15:0] BAUD_RELOAD_RST = 16'h0000;
   localparam logic [15:0] TX_BUFFER_RST   = 16'h0000;
   localparam logic [3:0]  CS_LINES_IDLE   = 4'hF;
   localparam logic [3:0]  WIDTH_MIN       = 4'h1;
   localparam logic [15:0] VEC_ERROR       = 16'hA004;
   localparam logic [15:0] VEC_RX          = 16'hA002;
   localparam logic [15:0] VEC_TX          = 16'h0000;
   localparam logic [15:0] VEC_TX_LOW      = 16'h0000;
   localparam logic [5:0]  CTRL_PAD        = 6'h00;
   localparam logic [17:0] GAP_MAX         = 18'h3_FFFE;
   localparam logic [17:0] GAP_ONE         = 18'h0_0001;

   // -----------------------------------------------------------------
   // field positions
   // -----------------------------------------------------------------
   localparam int ERR_RX_OVERRUN = 0;
   localparam int ERR_PHASE      = 1;
   localparam int ERR_RATE       = 2;
   localparam int ERR_TX_STALE   = 3;
   localparam int IRQ_TX         = 0;
   localparam int IRQ_RX         = 1;
   localparam int IRQ_ERR        = 2;

   // -----------------------------------------------------------------
   // types
   // -----------------------------------------------------------------
   typedef struct packed {
      logic       port_enable_bit;
      logic       master_select_bit;
      logic       clock_idle_level_bit;
      logic       clock_edge_phase_bit;
      logic       msb_first;
      logic [3:0] width;
      logic       auto_reinit_enable;
   } ssp_cfg_t;

   typedef struct packed {
      logic clk;
      logic master_out_slave_in_pin;
      logic master_in_slave_out_pin;
   } ssp_pins_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_LEAD  = 4'b0010,
      ST_SHIFT = 4'b0100,
      ST_TRAIL = 4'b1000
   } ssp_state_t;

endpackage

//--- ssp_baud_gen.sv
// module: reloading down-counter that paces the serial bit clock
module ssp_baud_gen
   import ssp_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic        ce_in,
   input  wire logic        run_in,
   input  wire logic [15:0] reload_in,
   output logic      [15:0] count_out,
   output logic             half_tick_out,
   output logic             full_tick_out
);

   logic        pre;
   logic [15:0] count;
   logic [15:0] mid;

   // -----------------------------------------------------------------
   // prescaler and timer
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pre <= 1'b0;
      end else if (ce_in) begin
         pre <= run_in ? ~pre : 1'b0;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         count <= BAUD_RELOAD_RST;
      end else if (ce_in) begin
         if (!run_in || full_tick_out) begin
            count <= reload_in;
         end else if (pre) begin
            count <= count - 16'h0001;
         end
      end
   end

   // -----------------------------------------------------------------
   // ticks: one per half bit, bit = 2 x (reload + 1) cycles
   // -----------------------------------------------------------------
   assign mid           = reload_in - {1'b0, reload_in[15:1]};
   assign full_tick_out = run_in && pre && (count == 16'h0000);
   assign half_tick_out = run_in && (count == mid) &&
                          (pre == reload_in[0]);
   assign count_out     = count;

endmodule // ssp_baud_gen

//--- ssp_ctrl.sv
// module: synchronous serial port controller, master or slave
//
// Contract
// - four chip selects follow each master transfer automatically
// - select leads and trails data by half bit
// - select used when its enable bit is zero
// - transmit request set when buffer empties
// - reloaded buffer continues shifting with no gap
// - pin equals port latch AND serial output
// - mode picks the serial input and output paths
// - sixteen bit down timer at half clock
// - baud read gives count enabled, reload disabled
// - bit rate is clock over 2(reload+1)
// - slave only detects transmit and rate errors
// - sticky error flags, enabled ones raise request
// - unread receive buffer overwritten, overrun flagged
// - input change near latch edge is phase error
// - slave clock off by factor two is error
// - rate error with auto reinit resets port
// - slave clocked without fresh buffer flags stale
// - each interrupt enabled by its mask bit
// - vector tags error and receive events
// - two to sixteen bits, right aligned data
// - frame end copies word, sets receive request
// - idle level and shifting edge are selectable
// - slave presents first bit on buffer load
module ssp_ctrl
   import ssp_pkg::*;
(
   input  wire logic              mclk_in,
   input  wire logic              rst_in,
   input  wire logic              ce_in,
   input  wire ssp_pkg::ssp_cfg_t cfg_in,
   input  wire logic [3:0]        cs_enable_in,
   input  wire logic [3:0]        err_enable_in,
   input  wire logic [2:0]        irq_mask_in,
   input  wire logic [15:0]       baud_reload_in,
   input  wire logic              baud_write_in,
   input  wire logic [15:0]       tx_data_in,
   input  wire logic              tx_write_in,
   input  wire logic              rx_read_in,
   input  wire logic [3:0]        err_clear_in,
   input  wire logic [2:0]        irq_ack_in,
   input  wire ssp_pkg::ssp_pins_t port_latch_in,
   input  wire ssp_pkg::ssp_pins_t pins_in,
   output ssp_pkg::ssp_pins_t     pins_out,
   output logic [3:0]             chip_select_line_n_out,
   output logic [15:0]            receive_buffer_out,
   output logic                   rx_full_out,
   output logic [3:0]             err_flags_out,
   output logic [2:0]             irq_req_out,
   output logic                   irq_out,
   output logic [31:0]            irq_vector_word_out,
   output logic [15:0]            baud_read_out,
   output logic                   busy_out
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic out_bit(input logic [15:0] w,
                                    input logic msb,
                                    input logic [3:0] sel);
      out_bit = msb ? w[sel] : w[0];
   endfunction

   function automatic logic [15:0] shift_word(input logic [15:0] w,
                                              input logic din,
                                              input logic msb,
                                              input logic [3:0] sel);
      logic [15:0] r;
      r = msb ? {w[14:0], din} : {1'b0, w[15:1]};
      if (!msb) begin
         r[sel] = din;
      end
      shift_word = r;
   endfunction

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   ssp_state_t  state;
   logic [15:0] transmit_buffer;
   logic [15:0] baud_reload_reg;
   logic [15:0] baud_count;
   logic [15:0] sr;
   logic [15:0] shifted;
   logic [15:0] next_sr;
   logic [15:0] port_control_reg;
   logic [17:0] gap;
   logic [17:0] interval;
   logic [17:0] h_cycles;
   logic [4:0]  edge_cnt;
   logic [4:0]  last_edge;
   logic [3:0]  wsel;
   logic [3:0]  new_err;
   logic [3:0]  err_flags;
   logic [2:0]  irq_req;
   logic [2:0]  din_hist;
   logic [1:0]  latch_dly;
   logic        half_tick;
   logic        full_tick;
   logic        tick;
   logic        run;
   logic        master;
   logic        tx_full;
   logic        tx_fresh;
   logic        sck;
   logic        dout;
   logic        rx_bit;
   logic        rx_full;
   logic        sclk_d;
   logic        slave_active;
   logic        din;
   logic        m_edge;
   logic        s_edge;
   logic        edge_now;
   logic        leading;
   logic        latch_edge;
   logic        shift_edge;
   logic        present_edge;
   logic        frame_done;
   logic        load_now;
   logic        tx_take;
   logic        lead_end;
   logic        slave_start;
   logic        reinit;
   logic        shift_in;

   // -----------------------------------------------------------------
   // baud generator
   // -----------------------------------------------------------------
   ssp_baud_gen u_baud (
      .mclk_in       (mclk_in),
      .rst_in        (rst_in),
      .ce_in         (ce_in),
      .run_in        (run && !(master && state == ST_IDLE)),
      .reload_in     (baud_reload_reg),
      .count_out     (baud_count),
      .half_tick_out (half_tick),
      .full_tick_out (full_tick)
   );

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         baud_reload_reg <= BAUD_RELOAD_RST;
      end else if (ce_in && baud_write_in && !run) begin
         baud_reload_reg <= baud_reload_in;
      end
   end

   // -----------------------------------------------------------------
   // edge decoding
   // -----------------------------------------------------------------
   assign run       = cfg_in.port_enable_bit;
   assign master    = cfg_in.master_select_bit;
   assign tick      = half_tick || full_tick;
   assign wsel      = (cfg_in.width < WIDTH_MIN) ? WIDTH_MIN
                                                 : cfg_in.width;
   assign last_edge = {wsel, 1'b1};
   assign din       = master ? pins_in.master_in_slave_out_pin
                             : pins_in.master_out_slave_in_pin;
   assign m_edge    = master && (state == ST_SHIFT) && tick;
   assign s_edge    = !master && run && (pins_in.clk != sclk_d);
   assign edge_now  = master ? m_edge : s_edge;
   assign leading   = ~edge_cnt[0];
   assign latch_edge = edge_now &&
      (cfg_in.clock_edge_phase_bit ? !leading : leading);
   assign present_edge = edge_now &&
      (cfg_in.clock_edge_phase_bit ? leading : !leading);
   assign shift_edge = present_edge && (edge_cnt != 5'h00);
   assign frame_done = edge_now && (edge_cnt == last_edge);
   assign lead_end   = master && (state == ST_LEAD) && tick;
   assign slave_start = s_edge && !slave_active &&
                        (pins_in.clk != cfg_in.clock_idle_level_bit);
   assign load_now   = tx_full && run && !frame_done &&
      ((master && state == ST_IDLE) ||
       (!master && !slave_active && !s_edge));
   assign tx_take    = load_now || (frame_done && tx_full);
   assign reinit     = new_err[ERR_RATE] &&
                       cfg_in.auto_reinit_enable;

   always_comb begin
      shift_in = (frame_done && cfg_in.clock_edge_phase_bit) ? din : rx_bit;
      shifted  = shift_word(sr, shift_in, cfg_in.msb_first, wsel);
      next_sr  = sr;
      if (frame_done) begin
         next_sr = tx_full ? transmit_buffer : shifted;
      end else if (load_now) begin
         next_sr = transmit_buffer;
      end else if (shift_edge) begin
         next_sr = shifted;
      end
   end

   // -----------------------------------------------------------------
   // error detection
   // -----------------------------------------------------------------
   assign h_cycles = {2'b00, baud_reload_reg} + GAP_ONE;
   assign interval = gap + GAP_ONE;

   always_comb begin
      new_err = 4'h0;
      new_err[ERR_RX_OVERRUN] = frame_done && rx_full &&
                                !rx_read_in;
      new_err[ERR_PHASE] = latch_dly[1] &&
         !((din == din_hist[0]) && (din == din_hist[1]) &&
           (din == din_hist[2]));
      new_err[ERR_RATE] = !master && slave_active &&
         ((s_edge && (interval < (h_cycles >> 1))) ||
          (!s_edge && (interval > (h_cycles << 1))));
      new_err[ERR_TX_STALE] = slave_start && !tx_fresh;
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         din_hist  <= 3'h0;
         latch_dly <= 2'h0;
         sclk_d    <= 1'b0;
      end else if (ce_in) begin
         din_hist  <= {din_hist[1:0], din};
         latch_dly <= {latch_dly[0], latch_edge};
         sclk_d    <= pins_in.clk;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         gap <= 18'h0_0000;
      end else if (ce_in) begin
         if (s_edge || !slave_active) begin
            gap <= 18'h0_0000;
         end else if (gap != GAP_MAX) begin
            gap <= gap + GAP_ONE;
         end
      end
   end

   // -----------------------------------------------------------------
   // master sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= ST_IDLE;
      end else if (ce_in) begin
         if (!run || !master) begin
            state <= ST_IDLE;
         end else begin
            case (state)
               ST_IDLE: begin
                  if (tx_full) begin
                     state <= ST_LEAD;
                  end
               end
               ST_LEAD: begin
                  if (tick) begin
                     state <= ST_SHIFT;
                  end
               end
               ST_SHIFT: begin
                  if (frame_done && !tx_full) begin
                     state <= ST_TRAIL;
                  end
               end
               ST_TRAIL: begin
                  if (tick) begin
                     state <= ST_IDLE;
                  end
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         sck <= 1'b0;
      end else if (ce_in) begin
         if (state == ST_IDLE) begin
            sck <= cfg_in.clock_idle_level_bit;
         end else if (m_edge) begin
            sck <= ~sck;
         end
      end
   end

   // -----------------------------------------------------------------
   // slave framing and edge count
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         slave_active <= 1'b0;
         edge_cnt     <= 5'h00;
      end else if (ce_in) begin
         if (!run || reinit || frame_done) begin
            slave_active <= 1'b0;
            edge_cnt     <= 5'h00;
         end else begin
            if (slave_start) begin
               slave_active <= 1'b1;
            end
            if (edge_now && (master || slave_active || slave_start)) begin
               edge_cnt <= edge_cnt + 5'h01;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // shift path
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         sr     <= TX_BUFFER_RST;
         rx_bit <= 1'b0;
         dout   <= 1'b1;
      end else if (ce_in) begin
         sr <= next_sr;
         if (latch_edge) begin
            rx_bit <= din;
         end
         if (load_now && !master) begin
            dout <= out_bit(transmit_buffer, cfg_in.msb_first,
                            wsel);
         end else if (lead_end) begin
            dout <= out_bit(sr, cfg_in.msb_first, wsel);
         end else if (present_edge && !(frame_done && !tx_full)) begin
            dout <= out_bit(next_sr, cfg_in.msb_first, wsel);
         end
      end
   end

   // -----------------------------------------------------------------
   // transmit and receive buffers
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         transmit_buffer <= TX_BUFFER_RST;
         tx_full         <= 1'b0;
         tx_fresh        <= 1'b0;
      end else if (ce_in) begin
         if (tx_write_in) begin
            transmit_buffer <= tx_data_in;
         end
         tx_full  <= tx_write_in || (tx_full && !tx_take);
         tx_fresh <= tx_write_in || (tx_fresh && !slave_start);
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         receive_buffer_out <= TX_BUFFER_RST;
         rx_full            <= 1'b0;
      end else if (ce_in) begin
         if (frame_done) begin
            receive_buffer_out <= shifted;
         end
         rx_full <= frame_done || (rx_full && !rx_read_in);
      end
   end

   // -----------------------------------------------------------------
   // flags and interrupt requests
   // -----------------------------------------------------------------
   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         err_flags <= 4'h0;
      end else if (ce_in) begin
         err_flags <= (err_flags & ~err_clear_in) | new_err;
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_req <= 3'h0;
      end else if (ce_in) begin
         irq_req[IRQ_TX] <= tx_take || (irq_req[IRQ_TX] &&
            !irq_ack_in[IRQ_TX] && !tx_write_in);
         irq_req[IRQ_RX] <= frame_done || (irq_req[IRQ_RX] &&
            !irq_ack_in[IRQ_RX] && !rx_read_in);
         irq_req[IRQ_ERR] <= (|(new_err & err_enable_in)) ||
            (irq_req[IRQ_ERR] && !irq_ack_in[IRQ_ERR]);
      end
   end

   assign port_control_reg = {CTRL_PAD, cfg_in};

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         irq_out             <= 1'b0;
         irq_vector_word_out <= 32'h0000_0000;
      end else if (ce_in) begin
         irq_out <= |(irq_req & irq_mask_in);
         if (irq_req[IRQ_ERR]) begin
            irq_vector_word_out <= {VEC_ERROR, port_control_reg};
         end else if (irq_req[IRQ_RX]) begin
            irq_vector_word_out <= {VEC_RX, receive_buffer_out};
         end else begin
            irq_vector_word_out <= {VEC_TX, VEC_TX_LOW};
         end
      end
   end

   // -----------------------------------------------------------------
   // pins, chip selects and status
   // -----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cs
         always_ff @(posedge mclk_in or posedge rst_in) begin
            if (rst_in) begin
               chip_select_line_n_out[gi] <= 1'b1;
            end else if (ce_in) begin
               chip_select_line_n_out[gi] <= (state == ST_IDLE) ||
                  cs_enable_in[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         pins_out <= '1;
      end else if (ce_in) begin
         pins_out.clk <= port_latch_in.clk &
            ((run && master) ? sck : 1'b1);
         pins_out.master_out_slave_in_pin <=
            port_latch_in.master_out_slave_in_pin &
            ((run && master) ? dout : 1'b1);
         pins_out.master_in_slave_out_pin <=
            port_latch_in.master_in_slave_out_pin &
            ((run && !master) ? dout : 1'b1);
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in) begin
      if (rst_in) begin
         baud_read_out <= BAUD_RELOAD_RST;
         busy_out      <= 1'b0;
      end else if (ce_in) begin
         baud_read_out <= run ? baud_count : baud_reload_reg;
         busy_out      <= (state != ST_IDLE) || slave_active;
      end
   end

   assign rx_full_out   = rx_full;
   assign err_flags_out = err_flags;
   assign irq_req_out   = irq_req;

endmodule // ssp_ctrl

//--- ssp_ctrl_props.sv
// checker: port level properties of the serial port controller
module ssp_ctrl_props
   import ssp_pkg::*;
(
   input wire logic               mclk_in,
   input wire logic               rst_in,
   input wire logic [3:0]         cs_enable_in,
   input wire logic [3:0]         err_enable_in,
   input wire logic [2:0]         irq_mask_in,
   input wire logic [3:0]         err_clear_in,
   input wire ssp_pkg::ssp_pins_t port_latch_in,
   input wire ssp_pkg::ssp_pins_t pins_out,
   input wire logic [3:0]         chip_select_line_n_out,
   input wire logic               rx_full_out,
   input wire logic [3:0]         err_flags_out,
   input wire logic [2:0]         irq_req_out,
   input wire logic               irq_out,
   input wire logic               busy_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   property p_cs_unused;
      ((~chip_select_line_n_out) & $past(cs_enable_in)) == 4'h0;
   endproperty
   a_cs_unused: assert property (p_cs_unused)
      else $error("disabled select line active");
   property p_pin_and;
      !port_latch_in.master_in_slave_out_pin |=>
         !pins_out.master_in_slave_out_pin;
   endproperty
   a_pin_and: assert property (p_pin_and)
      else $error("pin not gated by latch");
   property p_irq_mask;
      irq_out == $past(|(irq_req_out & irq_mask_in));
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("irq not masked request");
   property p_sticky;
      (($past(err_flags_out) & ~$past(err_clear_in)) & ~err_flags_out) == 4'h0;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("error flag dropped without clear");
   property p_err_req;
      $rose(err_flags_out[ERR_RX_OVERRUN]) && err_enable_in[ERR_RX_OVERRUN]
         |-> ##[0:2] irq_req_out[IRQ_ERR];
   endproperty
   a_err_req: assert property (p_err_req)
      else $error("overrun gave no error request");
   property p_rx_req;
      $rose(rx_full_out) |-> ##[0:1] irq_req_out[IRQ_RX];
   endproperty
   a_rx_req: assert property (p_rx_req)
      else $error("frame end gave no rx request");
   property p_cs_busy;
      $fell(chip_select_line_n_out[0]) |-> busy_out;
   endproperty
   a_cs_busy: assert property (p_cs_busy)
      else $error("select active outside transfer");
   property p_cs_idle;
      !busy_out ##1 !busy_out |-> chip_select_line_n_out == CS_LINES_IDLE;
   endproperty
   a_cs_idle: assert property (p_cs_idle)
      else $error("select not released when idle");
   c_rx: cover property ($rose(irq_req_out[IRQ_RX]));
   c_err: cover property ($rose(irq_req_out[IRQ_ERR]));
   c_cs: cover property ($fell(chip_select_line_n_out[0]));
endmodule // ssp_ctrl_props

bind ssp_ctrl ssp_ctrl_props ssp_ctrl_props_i (
   .mclk_in(mclk_in), .rst_in(rst_in), .cs_enable_in(cs_enable_in),
   .err_enable_in(err_enable_in), .irq_mask_in(irq_mask_in),
   .err_clear_in(err_clear_in), .port_latch_in(port_latch_in),
   .pins_out(pins_out), .chip_select_line_n_out(chip_select_line_n_out),
   .rx_full_out(rx_full_out), .err_flags_out(err_flags_out),
   .irq_req_out(irq_req_out), .irq_out(irq_out), .busy_out(busy_out));

//--- ssp_slave_model.sv
// partner: serial slave on select line 0, idle low clock, phase 0
module ssp_slave_model (
   input  wire logic        mclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        sck_in,
   input  wire logic        mosi_in,
   input  wire logic [15:0] word_in,
   output logic             miso_out,
   output logic [15:0]      rx_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        sck_q = 1'h0;
   logic        cs_q  = 1'h1;
   logic [15:0] sreg  = 16'hFFFF;
   assign miso_out = cs_n_in ? ~sreg[15] : sreg[15];
   always @(posedge mclk_in) begin
      sck_q <= sck_in;
      cs_q  <= cs_n_in;
      if (cs_q && !cs_n_in) begin
         sreg   <= word_in;
         rx_out <= 16'h0000;
      end else if (!cs_n_in && sck_in && !sck_q) begin
         rx_out <= {rx_out[14:0], mosi_in};
      end else if (!cs_n_in && !sck_in && sck_q) begin
         sreg <= {sreg[14:0], 1'h0};
      end
   end
endmodule // ssp_slave_model

//--- tb_sync_serial_port_ctrl.sv
// testbench: master traffic, errors and reset values
module tb_sync_serial_port_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import ssp_pkg::*;
   logic        mclk_in = 1'h0, rst_in = 1'h1;
   ssp_cfg_t    cfg = '0;
   logic [3:0]  err_clr = 4'h0, cs_n, flags;
   logic [2:0]  ack = 3'h0, req, msk = 3'h6;
   logic [15:0] tx = 16'h0000, sword = 16'h0000, rbuf, baud_rd, srx;
   logic        bwr = 1'h0, twr = 1'h0, rrd = 1'h0, rx_full, irq, busy, miso;
   ssp_pins_t   pins_i, pins_o;
   logic [31:0] vec;
   int          error_cnt = 0, tests_run = 0, n;
   always #2 mclk_in = ~mclk_in;
   assign pins_i = '{pins_o.clk, pins_o.master_out_slave_in_pin, miso};
   ssp_ctrl ssp_ctrl_i (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(1'h1),
      .cfg_in(cfg), .cs_enable_in(4'hE), .err_enable_in(4'h1),
      .irq_mask_in(msk), .baud_reload_in(16'h0003), .baud_write_in(bwr),
      .tx_data_in(tx), .tx_write_in(twr), .rx_read_in(rrd),
      .err_clear_in(err_clr), .irq_ack_in(ack), .port_latch_in(3'h6),
      .pins_in(pins_i), .pins_out(pins_o), .chip_select_line_n_out(cs_n),
      .receive_buffer_out(rbuf), .rx_full_out(rx_full), .err_flags_out(flags),
      .irq_req_out(req), .irq_out(irq), .irq_vector_word_out(vec),
      .baud_read_out(baud_rd), .busy_out(busy));
   ssp_slave_model ssp_slave_model_i (.mclk_in(mclk_in), .cs_n_in(cs_n[0]),
      .sck_in(pins_o.clk), .mosi_in(pins_o.master_out_slave_in_pin),
      .word_in(sword), .miso_out(miso), .rx_out(srx));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic step(input int k);
      repeat (k) @(posedge mclk_in);
   endtask
   task automatic send(input logic [15:0] d);
      tx  <= d;
      twr <= 1'h1;
      step(1);
      twr <= 1'h0;
   endtask
   task automatic wait_idle();
      step(4);
      for (n = 0; n < 400 && (busy !== 1'h0 || cs_n !== 4'hF); n++) step(1);
      if (n == 400) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task automatic t_reset_baud();
      chk({cs_n, flags, req, pins_o}, {4'hF, 4'h0, 3'h0, 3'h6});
      bwr <= 1'h1;
      step(1);
      bwr <= 1'h0;
      step(3);
      chk(baud_rd, 16'h0003);
      cfg <= '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 4'h7, 1'h0};
      step(3);
   endtask
   task automatic t_single();
      sword <= 16'hA500;
      send(16'h00C3);
      for (n = 0; n < 99 && pins_o.clk !== 1'h1; n++) step(1);
      chk(cs_n, 4'hE);
      for (n = 0; n < 99 && pins_o.clk !== 1'h0; n++) step(1);
      while (n < 99 && pins_o.clk !== 1'h1) begin
         step(1);
         n++;
      end
      chk(n, 8);
      wait_idle();
      chk(srx[7:0], 8'hC3);
      chk({rx_full, req[IRQ_RX], irq, rbuf[7:0]}, {3'h7, 8'hA5});
      chk({vec[31:16], vec[7:0]}, {VEC_RX, 8'hA5});
   endtask
   task automatic t_overrun();
      sword <= 16'h3C00;
      send(16'h005A);
      wait_idle();
      chk({flags[ERR_RX_OVERRUN], rbuf[7:0]}, {1'h1, 8'h3C});
      chk(req[IRQ_ERR], 1'h1);
      chk(vec, {VEC_ERROR, CTRL_PAD, cfg});
      msk <= 3'h0;
      step(2);
      chk(irq, 1'h0);
      msk     <= 3'h6;
      err_clr <= 4'hF;
      ack     <= 3'h7;
      rrd     <= 1'h1;
      step(1);
      {err_clr, ack, rrd} <= '0;
      step(2);
      chk({flags, req}, 7'h00);
   endtask
   task automatic t_gapless();
      sword <= 16'h1234;
      send(16'h0081);
      step(6);
      chk(req[IRQ_TX], 1'h1);
      send(16'h007E);
      wait_idle();
      chk({srx, rbuf[7:0]}, {16'h817E, 8'h34});
   endtask
   initial begin
      step(8);
      rst_in <= 1'h0;
      step(2);
      t_reset_baud();
      t_single();
      t_overrun();
      t_gapless();
      tally_and_finish();
   end
endmodule // tb_sync_serial_port_ctrl
